// File: rtl/tsc_pkg.sv
// Shared constants of the asynchronous timer register block
package tsc_pkg;
    // ****************************************
    // Register addresses
    // ****************************************
    localparam logic [7:0] ADDR_GEN_CTRL = 8'h43;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h70;
    localparam logic [7:0] ADDR_CMP_B = 8'hb4;
    localparam logic [7:0] ADDR_ASYNC_STAT = 8'hb6;
    localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h37;
    localparam logic [7:0] ADDR_CTRL_A = 8'hb0;
    localparam logic [7:0] ADDR_CTRL_B = 8'hb1;
    localparam logic [7:0] ADDR_COUNTER = 8'hb2;
    localparam logic [7:0] ADDR_CMP_A = 8'hb3;
    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int BIT_OVF = 0;
    localparam int BIT_CMPA = 1;
    localparam int BIT_CMPB = 2;
    localparam int BIT_AS = 5;
    localparam int BIT_EXTERNAL_CLOCK_ENABLE = 6;
    localparam int BIT_PSR = 1;
    localparam int BIT_TSM = 7;
    localparam int BIT_WGM2 = 3;
    localparam int BIT_FOCB = 6;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] CTRL_B_RD_MASK = 8'h0f;
    localparam logic [7:0] CTRL_A_RD_MASK = 8'hf3;
    localparam logic [7:0] CNT_MAX = 8'hff;
    localparam logic [7:0] CNT_BOTTOM = 8'h00;
    // Busy bit index per delayed register: counter, cmp a, cmp b, ctrl a, ctrl b
    localparam int NUM_DLY = 5;
    localparam int BUSY_CNT = 4;
    localparam int BUSY_CMPA = 3;
    localparam int BUSY_CMPB = 2;
    localparam int BUSY_CTLA = 1;
    localparam int BUSY_CTLB = 0;
    // Prescaler divide-by masks for clock selects 1 to 7
    localparam logic [9:0] PRE_MASK1 = 10'h000;
    localparam logic [9:0] PRE_MASK2 = 10'h007;
    localparam logic [9:0] PRE_MASK3 = 10'h01f;
    localparam logic [9:0] PRE_MASK4 = 10'h03f;
    localparam logic [9:0] PRE_MASK5 = 10'h07f;
    localparam logic [9:0] PRE_MASK6 = 10'h0ff;
    localparam logic [9:0] PRE_MASK7 = 10'h3ff;
endpackage

// File: rtl/tsc_prescaler.sv
// Timer prescaler with selectable divide tap and hold-in-reset
`timescale 1ns/1ps
module tsc_prescaler import tsc_pkg::*; (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic src_tick,
    input wire logic clear,
    input wire logic [2:0] sel,
    output logic tick
);
    logic [9:0] div_q;
    logic [9:0] mask;
    always_comb begin
        case (sel)
            3'h1: mask = PRE_MASK1;
            3'h2: mask = PRE_MASK2;
            3'h3: mask = PRE_MASK3;
            3'h4: mask = PRE_MASK4;
            3'h5: mask = PRE_MASK5;
            3'h6: mask = PRE_MASK6;
            default: mask = PRE_MASK7;
        endcase
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= 10'h000;
        end else if (clear) begin
            div_q <= 10'h000;
        end else if (src_tick) begin
            div_q <= div_q + 10'h001;
        end
    end
    assign tick = src_tick & ~clear & (sel != 3'h0) & ((div_q & mask) == mask);
endmodule

// File: rtl/tsc_sync2.sv
// Two-stage synchroniser for the timer oscillator pin
`timescale 1ns/1ps
module tsc_sync2 (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_q;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

// File: rtl/tsc_timer.sv
// Asynchronous-capable 8-bit timer: compare, flags, busy handshake, prescaler reset
// Function
// RULE1: Compare-B value is compared with counter; match drives flag and wave pin.
// RULE2: Compare-B interrupt requested when its flag, enable bit 2 and global enable set.
// RULE3: Compare-A interrupt requested when its flag, enable bit 1 and global enable set.
// RULE4: Overflow interrupt requested when its flag, enable bit 0 and global enable set.
// RULE5: Compare-B flag, bit 2, sets on counter match with compare-B.
// RULE6: Compare-B flag clears on vector execution or software writing one.
// RULE7: Compare-A flag, bit 1, sets on counter match with compare-A.
// RULE8: Compare-A flag clears on vector or writing one; writing zero does nothing.
// RULE9: Overflow flag sets on overflow, or at bottom direction change in PWM.
// RULE10: Overflow flag clears on vector execution or software writing one.
// RULE11: Unused status bit 7 and upper five mask bits read zero.
// RULE12: External clock buffer enabled with async mode; crystal runs only when bit zero.
// RULE13: Software sets external-clock enable before selecting asynchronous clocking.
// RULE14: Async select zero uses system clock, one uses oscillator pin.
// RULE15: Software rewrites timer registers after changing the async select bit.
// RULE16: Async writes to delayed registers set busy bits until transferred.
// RULE17: Software never writes a delayed register while its busy bit is set.
// RULE18: Counter reads live value; compare and control reads return temporary storage.
// RULE19: Prescaler reset bit resets prescaler; clears at once, or after reset in async.
// RULE20: Prescaler reset bit is never cleared while sync mode bit is set.
// RULE21: Prescaler stays in reset while the reset bit is held by sync mode.
`timescale 1ns/1ps
module tsc_timer import tsc_pkg::*; (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rd_data,
    input wire logic global_irq_enable,
    input wire logic [2:0] vector_ack,
    input wire logic timer_osc_in_pin,
    output logic [2:0] irq_req,
    output logic compare_b_wave_pin,
    output logic ext_clk_buf_en,
    output logic crystal_osc_en
);
    // ****************************************
    // Register state
    // ****************************************
    logic [7:0] counter_value_q;
    logic [7:0] tmp_q [NUM_DLY];
    logic [7:0] compare_a_value_q;
    logic [7:0] compare_b_value_q;
    logic [7:0] control_a_reg_q;
    logic [7:0] control_b_reg_q;
    logic [NUM_DLY-1:0] busy_q;
    logic [2:0] mask_q;
    logic [2:0] flag_q;
    logic external_clock_enable_q;
    logic async_clock_select_q;
    logic timer_sync_mode_q;
    logic async_prescaler_reset_q;
    logic count_up_q;
    logic block_q;
    logic wave_q;
    logic osc_sync;
    logic osc_last_q;
    logic osc_rise;
    logic src_tick;
    logic cnt_tick;
    logic [7:0] top;
    logic [2:0] mode;
    logic phase_pwm;
    logic fast_pwm;
    logic match_a;
    logic match_b;
    logic ovf_evt;
    logic at_bottom;
    logic [7:0] cnt_d;
    logic wave_d;
    logic [2:0] flag_clr;
    logic [NUM_DLY-1:0] dly_wr;
    logic [7:0] rd_d;

    // ****************************************
    // Timer clock source
    // ****************************************
    tsc_sync2 u_osc_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .async_in(timer_osc_in_pin),
        .sync_out(osc_sync)
    );

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            osc_last_q <= 1'b0;
        end else begin
            osc_last_q <= osc_sync;
        end
    end

    assign osc_rise = osc_sync & ~osc_last_q;
    assign src_tick = async_clock_select_q ? osc_rise : 1'b1; // RULE14

    tsc_prescaler u_pre (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .src_tick(src_tick),
        .clear(async_prescaler_reset_q), // RULE21
        .sel(control_b_reg_q[2:0]),
        .tick(cnt_tick)
    );

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ext_clk_buf_en <= 1'b0;
            crystal_osc_en <= 1'b0;
        end else begin
            ext_clk_buf_en <= external_clock_enable_q & async_clock_select_q; // RULE12
            crystal_osc_en <= async_clock_select_q & ~external_clock_enable_q; // RULE12
        end
    end

    // ****************************************
    // Register writes
    // ****************************************
    always_comb begin
        dly_wr = '0;
        if (wr_en) begin
            dly_wr[BUSY_CNT] = (addr == ADDR_COUNTER);
            dly_wr[BUSY_CMPA] = (addr == ADDR_CMP_A);
            dly_wr[BUSY_CMPB] = (addr == ADDR_CMP_B);
            dly_wr[BUSY_CTLA] = (addr == ADDR_CTRL_A);
            dly_wr[BUSY_CTLB] = (addr == ADDR_CTRL_B);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mask_q <= 3'h0;
            external_clock_enable_q <= 1'b0;
            async_clock_select_q <= 1'b0;
            timer_sync_mode_q <= 1'b0;
        end else if (wr_en) begin
            if (addr == ADDR_IRQ_MASK) begin
                mask_q <= wr_data[2:0];
            end
            if (addr == ADDR_ASYNC_STAT) begin
                external_clock_enable_q <= wr_data[BIT_EXTERNAL_CLOCK_ENABLE];
                async_clock_select_q <= wr_data[BIT_AS];
            end
            if (addr == ADDR_GEN_CTRL) begin
                timer_sync_mode_q <= wr_data[BIT_TSM];
            end
        end
    end

    // Temporary storage; busy set on async write, cleared on transfer
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            busy_q <= '0;
            for (int i = 0; i < NUM_DLY; i++) begin
                tmp_q[i] <= REG_RESET;
            end
        end else begin
            for (int i = 0; i < NUM_DLY; i++) begin
                if (dly_wr[i]) begin
                    tmp_q[i] <= wr_data;
                end
                if (dly_wr[i] && async_clock_select_q) begin
                    busy_q[i] <= 1'b1; // RULE16
                end else if (osc_rise || !async_clock_select_q) begin
                    busy_q[i] <= 1'b0; // RULE16
                end
            end
        end
    end

    // Working copies load directly in sync mode, on oscillator edge in async mode
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            compare_a_value_q <= REG_RESET;
            compare_b_value_q <= REG_RESET;
            control_a_reg_q <= REG_RESET;
            control_b_reg_q <= REG_RESET;
        end else if (!async_clock_select_q) begin
            if (dly_wr[BUSY_CMPA]) compare_a_value_q <= wr_data;
            if (dly_wr[BUSY_CMPB]) compare_b_value_q <= wr_data;
            if (dly_wr[BUSY_CTLA]) control_a_reg_q <= wr_data & CTRL_A_RD_MASK;
            if (dly_wr[BUSY_CTLB]) control_b_reg_q <= wr_data & CTRL_B_RD_MASK;
        end else if (osc_rise) begin
            if (busy_q[BUSY_CMPA]) compare_a_value_q <= tmp_q[BUSY_CMPA]; // RULE16
            if (busy_q[BUSY_CMPB]) compare_b_value_q <= tmp_q[BUSY_CMPB]; // RULE16
            if (busy_q[BUSY_CTLA]) control_a_reg_q <= tmp_q[BUSY_CTLA] & CTRL_A_RD_MASK;
            if (busy_q[BUSY_CTLB]) control_b_reg_q <= tmp_q[BUSY_CTLB] & CTRL_B_RD_MASK;
        end
    end

    // Prescaler reset: held while the sync mode bit is set, else one cycle in sync mode, until the oscillator edge in async mode
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            async_prescaler_reset_q <= 1'b0;
        end else if (wr_en && addr == ADDR_GEN_CTRL && wr_data[BIT_PSR]) begin
            async_prescaler_reset_q <= 1'b1; // RULE19
        end else if (timer_sync_mode_q) begin
            async_prescaler_reset_q <= async_prescaler_reset_q; // RULE20
        end else if (!async_clock_select_q || osc_rise) begin
            async_prescaler_reset_q <= 1'b0; // RULE19
        end
    end

    // ****************************************
    // Counter and compare
    // ****************************************
    assign mode = {control_b_reg_q[BIT_WGM2], control_a_reg_q[1:0]};
    assign phase_pwm = (mode[1:0] == 2'h1);
    assign fast_pwm = (mode[1:0] == 2'h3);
    assign top = (mode == 3'h2 || mode == 3'h5 || mode == 3'h7) ? compare_a_value_q : CNT_MAX;
    assign match_a = cnt_tick & ~block_q & (counter_value_q == compare_a_value_q); // RULE7
    assign match_b = cnt_tick & ~block_q & (counter_value_q == compare_b_value_q); // RULE1 RULE5
    assign at_bottom = cnt_tick & fast_pwm & (counter_value_q == top);

    always_comb begin
        cnt_d = counter_value_q;
        ovf_evt = 1'b0;
        if (cnt_tick) begin
            if (phase_pwm) begin
                if (count_up_q) begin
                    cnt_d = (counter_value_q == top) ? counter_value_q - 8'h01 : counter_value_q + 8'h01;
                end else if (counter_value_q == CNT_BOTTOM) begin
                    cnt_d = CNT_BOTTOM + 8'h01;
                    ovf_evt = 1'b1; // RULE9
                end else begin
                    cnt_d = counter_value_q - 8'h01;
                end
            end else begin
                cnt_d = (counter_value_q == top) ? CNT_BOTTOM : counter_value_q + 8'h01;
                ovf_evt = (counter_value_q == CNT_MAX) || (mode == 3'h7 && counter_value_q == top); // RULE9
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            counter_value_q <= REG_RESET;
            count_up_q <= 1'b1;
            block_q <= 1'b0;
        end else begin
            if (!async_clock_select_q && dly_wr[BUSY_CNT]) begin
                counter_value_q <= wr_data;
                block_q <= 1'b1;
            end else if (async_clock_select_q && osc_rise && busy_q[BUSY_CNT]) begin
                counter_value_q <= tmp_q[BUSY_CNT];
                block_q <= 1'b1;
            end else begin
                counter_value_q <= cnt_d;
                if (cnt_tick) block_q <= 1'b0;
            end
            if (!phase_pwm) begin
                count_up_q <= 1'b1;
            end else if (cnt_tick && count_up_q && counter_value_q == top) begin
                count_up_q <= 1'b0;
            end else if (cnt_tick && !count_up_q && counter_value_q == CNT_BOTTOM) begin
                count_up_q <= 1'b1;
            end
        end
    end

    // Compare-B wave output
    always_comb begin
        wave_d = wave_q;
        if (phase_pwm) begin
            if (match_b && control_a_reg_q[5]) wave_d = count_up_q ^ ~control_a_reg_q[4]; // RULE1
        end else if (fast_pwm) begin
            if (match_b && control_a_reg_q[5]) wave_d = control_a_reg_q[4]; // RULE1
            else if (at_bottom && control_a_reg_q[5]) wave_d = ~control_a_reg_q[4];
        end else if (match_b || (dly_wr[BUSY_CTLB] && !async_clock_select_q && wr_data[BIT_FOCB])) begin
            case (control_a_reg_q[5:4])
                2'h1: wave_d = ~wave_q;
                2'h2: wave_d = 1'b0;
                2'h3: wave_d = 1'b1;
                default: wave_d = wave_q;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wave_q <= 1'b0;
        end else begin
            wave_q <= wave_d;
        end
    end
    assign compare_b_wave_pin = wave_q;

    // ****************************************
    // Flags and requests
    // ****************************************
    assign flag_clr = vector_ack | ((wr_en && addr == ADDR_IRQ_FLAGS) ? wr_data[2:0] : 3'h0); // RULE6 RULE8 RULE10

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            flag_q <= 3'h0;
            irq_req <= 3'h0;
        end else begin
            flag_q <= (flag_q & ~flag_clr) | {match_b, match_a, ovf_evt}; // RULE5 RULE7 RULE9
            irq_req <= flag_q & mask_q & {3{global_irq_enable}}; // RULE2 RULE3 RULE4
        end
    end

    // ****************************************
    // Read port
    // ****************************************
    always_comb begin
        case (addr)
            ADDR_COUNTER: rd_d = counter_value_q; // RULE18
            ADDR_CMP_A: rd_d = tmp_q[BUSY_CMPA]; // RULE18
            ADDR_CMP_B: rd_d = tmp_q[BUSY_CMPB]; // RULE18
            ADDR_CTRL_A: rd_d = tmp_q[BUSY_CTLA] & CTRL_A_RD_MASK;
            ADDR_CTRL_B: rd_d = tmp_q[BUSY_CTLB] & CTRL_B_RD_MASK;
            ADDR_IRQ_MASK: rd_d = {5'h00, mask_q}; // RULE11
            ADDR_IRQ_FLAGS: rd_d = {5'h00, flag_q};
            ADDR_ASYNC_STAT: rd_d = {1'b0, external_clock_enable_q, async_clock_select_q, busy_q}; // RULE11
            ADDR_GEN_CTRL: rd_d = {timer_sync_mode_q, 5'h00, async_prescaler_reset_q, 1'b0};
            default: rd_d = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= 8'h00;
        end else begin
            rd_data <= rd_en ? rd_d : 8'h00;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    compare_b_flag_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE5
        match_b |=> flag_q[BIT_CMPB]) else $error("compare-b flag not set");
    compare_a_flag_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE7
        match_a |=> flag_q[BIT_CMPA]) else $error("compare-a flag not set");
    overflow_flag_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE9
        ovf_evt |=> flag_q[BIT_OVF]) else $error("overflow flag not set");
    flag_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE8
        (flag_clr[BIT_CMPA] && !match_a) |=> !flag_q[BIT_CMPA]) else $error("compare-a flag not cleared");
    irq_b_req_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE2
        (flag_q[BIT_CMPB] && mask_q[BIT_CMPB] && global_irq_enable) |=> irq_req[BIT_CMPB])
        else $error("compare-b request missing");
    irq_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE4
        !global_irq_enable |=> irq_req == 3'h0) else $error("request without global enable");
    busy_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE16
        (dly_wr[BUSY_CMPB] && async_clock_select_q) |=> busy_q[BUSY_CMPB]) else $error("busy not set");
    busy_done_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE16
        (busy_q[BUSY_CMPB] && osc_rise && async_clock_select_q && !dly_wr[BUSY_CMPB])
        |=> !busy_q[BUSY_CMPB] && compare_b_value_q == $past(tmp_q[BUSY_CMPB]))
        else $error("compare-b transfer wrong");
    psr_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE20
        (async_prescaler_reset_q && timer_sync_mode_q) |=> async_prescaler_reset_q)
        else $error("prescaler reset cleared in sync mode");
    psr_sync_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE19
        (async_prescaler_reset_q && !timer_sync_mode_q && !async_clock_select_q && !wr_en)
        |=> !async_prescaler_reset_q) else $error("prescaler reset not cleared");
    read_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE11
        (rd_en && addr == ADDR_IRQ_MASK) |=> rd_data[7:3] == 5'h00) else $error("mask upper bits nonzero");
    live_count_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE18
        (rd_en && addr == ADDR_COUNTER) |=> rd_data == $past(counter_value_q)) else $error("counter read wrong");
    async_cover_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
        busy_q[BUSY_CMPB] ##[1:50] !busy_q[BUSY_CMPB]);
    irq_cover_c: cover property (@(posedge clk_sys) disable iff (!rst_n) irq_req[BIT_CMPB]);
    psr_cover_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
        async_prescaler_reset_q && timer_sync_mode_q ##1 !timer_sync_mode_q);
endmodule

// File: verif/tb_async_timer2_irq_sync_regs.sv
// Self-checking register-level testbench of the asynchronous timer block
`timescale 1ns/1ps
module tb_async_timer2_irq_sync_regs import tsc_pkg::*; ;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wr_data = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic global_irq_enable = 1'b0;
    logic [2:0] vector_ack = 3'h0;
    logic timer_osc_in_pin = 1'b0;
    logic [7:0] rd_data;
    logic [2:0] irq_req;
    logic compare_b_wave_pin;
    logic ext_clk_buf_en;
    logic crystal_osc_en;
    int num_errors = 0;
    int n_checks = 0;
    int cycles = 0;
    localparam int MAX_CYCLES = 6000;

    tsc_timer DUT (.clk_sys(clk_sys), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
        .rd_en(rd_en), .rd_data(rd_data), .global_irq_enable(global_irq_enable), .vector_ack(vector_ack),
        .timer_osc_in_pin(timer_osc_in_pin), .irq_req(irq_req), .compare_b_wave_pin(compare_b_wave_pin),
        .ext_clk_buf_en(ext_clk_buf_en), .crystal_osc_en(crystal_osc_en));

    // ****************************************
    // Clock and hang guard
    // ****************************************
    initial begin
        forever #4 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == MAX_CYCLES) begin
            num_errors = num_errors + 1;
            $display("[ERR] %0t timeout", $time);
            final_report();
        end
    end

    // ****************************************
    // Bus tasks and comparisons
    // ****************************************
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        wr_en <= 1'b1;
        addr <= a;
        wr_data <= d;
        @(posedge clk_sys);
        wr_en <= 1'b0;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clk_sys);
        rd_en <= 1'b0;
        #1;
        chk(rd_data, exp, $sformatf("read %h", a));
    endtask

    task automatic ack(input int i);
        @(posedge clk_sys);
        vector_ack <= 3'(1 << i);
        @(posedge clk_sys);
        vector_ack <= 3'h0;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd_chk(ADDR_IRQ_MASK, REG_RESET);
        rd_chk(ADDR_CMP_B, REG_RESET);
        rd_chk(ADDR_ASYNC_STAT, REG_RESET);
        rd_chk(ADDR_GEN_CTRL, REG_RESET);
        rd_chk(8'h55, 8'h00);
        wr(ADDR_IRQ_MASK, 8'hff);
        rd_chk(ADDR_IRQ_MASK, 8'h07);
        $display("test reset and mask done");

        wr(ADDR_ASYNC_STAT, 8'hc0);
        rd_chk(ADDR_ASYNC_STAT, 8'h40);
        idle(2);
        chk({6'h0, ext_clk_buf_en, crystal_osc_en}, 8'h00, "clock enables sync");
        wr(ADDR_ASYNC_STAT, 8'h60);
        idle(2);
        chk({6'h0, ext_clk_buf_en, crystal_osc_en}, 8'h02, "external clock");
        wr(ADDR_ASYNC_STAT, 8'h20);
        idle(2);
        chk({6'h0, ext_clk_buf_en, crystal_osc_en}, 8'h01, "crystal clock");
        wr(ADDR_CMP_B, 8'h5a);
        wr(ADDR_GEN_CTRL, 8'h02);
        rd_chk(ADDR_ASYNC_STAT, 8'h24);
        rd_chk(ADDR_CMP_B, 8'h5a);
        rd_chk(ADDR_GEN_CTRL, 8'h02);
        @(posedge clk_sys);
        timer_osc_in_pin <= 1'b1;
        idle(10);
        rd_chk(ADDR_ASYNC_STAT, 8'h20);
        rd_chk(ADDR_GEN_CTRL, 8'h00);
        @(posedge clk_sys);
        timer_osc_in_pin <= 1'b0;
        wr(ADDR_ASYNC_STAT, 8'h00);
        rd_chk(ADDR_ASYNC_STAT, 8'h00);
        $display("test async clocking done");

        wr(ADDR_CMP_B, 8'h40);
        wr(ADDR_CMP_A, 8'h00);
        wr(ADDR_IRQ_MASK, 8'h07);
        global_irq_enable <= 1'b1;
        wr(ADDR_CTRL_B, 8'h01);
        idle(300);
        wr(ADDR_CTRL_B, 8'h00);
        idle(3);
        rd_chk(ADDR_IRQ_FLAGS, 8'h07);
        chk({5'h0, irq_req}, 8'h07, "irq all");
        @(posedge clk_sys);
        global_irq_enable <= 1'b0;
        idle(3);
        chk({5'h0, irq_req}, 8'h00, "irq global off");
        @(posedge clk_sys);
        global_irq_enable <= 1'b1;
        wr(ADDR_IRQ_FLAGS, 8'h00);
        rd_chk(ADDR_IRQ_FLAGS, 8'h07);
        wr(ADDR_IRQ_FLAGS, 8'h04);
        rd_chk(ADDR_IRQ_FLAGS, 8'h03);
        ack(1);
        rd_chk(ADDR_IRQ_FLAGS, 8'h01);
        idle(2);
        chk({5'h0, irq_req}, 8'h01, "irq overflow only");
        wr(ADDR_IRQ_FLAGS, 8'h01);
        rd_chk(ADDR_IRQ_FLAGS, 8'h00);
        wr(ADDR_CTRL_B, 8'h01);
        idle(300);
        wr(ADDR_CTRL_B, 8'h00);
        idle(3);
        ack(0);
        ack(2);
        rd_chk(ADDR_IRQ_FLAGS, 8'h02);
        wr(ADDR_COUNTER, 8'h10);
        rd_chk(ADDR_COUNTER, 8'h10);
        wr(ADDR_CTRL_A, 8'h10);
        rd_chk(ADDR_CTRL_A, 8'h10);
        wr(ADDR_CTRL_B, 8'h40);
        idle(2);
        chk({7'h0, compare_b_wave_pin}, 8'h01, "wave forced toggle");
        wr(ADDR_CMP_B, 8'h14);
        wr(ADDR_CTRL_B, 8'h01);
        idle(20);
        wr(ADDR_CTRL_B, 8'h00);
        idle(2);
        chk({7'h0, compare_b_wave_pin}, 8'h00, "wave match toggle");
        $display("test flags and requests done");

        wr(ADDR_GEN_CTRL, 8'h02);
        idle(3);
        rd_chk(ADDR_GEN_CTRL, 8'h00);
        wr(ADDR_GEN_CTRL, 8'h82);
        wr(ADDR_COUNTER, 8'h33);
        wr(ADDR_CTRL_B, 8'h01);
        idle(5);
        rd_chk(ADDR_GEN_CTRL, 8'h82);
        rd_chk(ADDR_COUNTER, 8'h33);
        wr(ADDR_GEN_CTRL, 8'h00);
        wr(ADDR_CTRL_B, 8'h00);
        idle(3);
        rd_chk(ADDR_GEN_CTRL, 8'h00);
        $display("test prescaler reset done");
        final_report();
    end
endmodule
